// [node_identity_pkg.sv]
// Package for the node identity and ROM mapping register bank.
// Assumes a single 50 MHz system clock domain.
package node_identity_pkg;
    localparam logic [7:0] NODE_ID_UPPER_OFS = 8'h24;
    localparam logic [7:0] NODE_ID_LOWER_OFS = 8'h28;
    localparam logic [7:0] ROM_IMAGE_MAPPING_OFS = 8'h34;
    localparam logic [7:0] FAILED_WRITE_OFFSET_LOW_OFS = 8'h38;
    localparam logic [7:0] FAILED_WRITE_OFFSET_HIGH_OFS = 8'h3c;
    // Bus option word has no printed offset here; placed at a chosen address
    localparam logic [7:0] BUS_OPTION_FIELDS_OFS = 8'h20;
    localparam logic [31:0] NODE_ID_RESET = 32'h0000_0000;
    localparam logic [31:0] ROM_IMAGE_MAPPING_RESET = 32'h0000_0000;
    localparam logic [1:0] GENERATION_RESET = 2'h0;
    localparam int GENERATION_LSB = 6;
    localparam int GENERATION_MSB = 7;
    localparam logic [2:0] LINK_SPEED_CODE = 3'h2;
    localparam int ROM_BASE_LSB = 10;
    localparam logic [47:0] ROM_WINDOW_FIRST = 48'hffff_f000_0400;
    localparam logic [47:0] ROM_WINDOW_LAST = 48'hffff_f000_07ff;
endpackage

// [node_identity_rom_map_regs.sv]
// Node identity, configuration ROM mapping and failed posted write capture registers.
// Assumes a simple register port with one-cycle read/write strobes and synchronous inputs.
// Summary of operation
// RQ1 - Bus option bits 11:8 and 5:3 read as zero.
// RQ2 - Two-bit ROM generation counter at bits 7:6 is writable, advanced at the next bus reset after ROM changes.
// RQ3 - Link speed code bits 2:0 read as binary 010.
// RQ4 - Upper identifier quadlet is a read-only register.
// RQ5 - Hardware reset clears upper identifier to zero.
// RQ6 - With EEPROM present, identifier quadlets load from EEPROM after PCI reset.
// RQ7 - Lower identifier quadlet is read-only, cleared on reset, loaded likewise.
// RQ8 - Writable ROM image base in bits 31:10.
// RQ9 - ROM window quadlet read address is base plus offset low ten bits.
// RQ10 - Mapping register bits 9:0 held zero and read zero.
// RQ11 - A failed posted write records its error details.
// RQ12 - Failed write low offset bits captured in read-only register.
// RQ13 - Requester bus, node and upper offset bits captured in companion register.
// RQ14 - Writes to read-only and reserved bits are ignored.
`timescale 1ns/1ns
module node_identity_rom_map_regs (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic eeprom_load,
    input wire logic [63:0] eeprom_identifier,
    input wire logic rom_changed,
    input wire logic bus_reset,
    input wire logic rom_read_req,
    input wire logic [47:0] rom_read_offset,
    output logic rom_fetch_valid,
    output logic [31:0] rom_fetch_addr,
    input wire logic posted_write_fail,
    input wire logic [15:0] failed_requester_node,
    input wire logic [47:0] failed_write_offset
);
    logic [31:0] node_id_upper_q;
    logic [31:0] node_id_lower_q;
    logic [21:0] rom_image_base_q;
    logic [1:0] generation_q;
    logic rom_dirty_q;
    logic [31:0] failed_write_offset_low_q;
    logic [31:0] failed_write_offset_high_q;
    logic [31:0] rdata_d;
    logic [31:0] reg_rdata_q;
    logic rom_fetch_valid_q;
    logic [31:0] rom_fetch_addr_q;

    wire logic wr_map = reg_wr && reg_addr == node_identity_pkg::ROM_IMAGE_MAPPING_OFS;
    wire logic wr_opts = reg_wr && reg_addr == node_identity_pkg::BUS_OPTION_FIELDS_OFS;
    wire logic in_window = rom_read_offset >= node_identity_pkg::ROM_WINDOW_FIRST
        && rom_read_offset <= node_identity_pkg::ROM_WINDOW_LAST;
    wire logic [31:0] map_word = {rom_image_base_q, 10'h000}; // RQ10
    wire logic [31:0] fetch_addr_d = map_word + {22'h000000, rom_read_offset[9:0]}; // RQ9
    wire logic [31:0] opts_word = {24'h000000, generation_q, 3'h0,
        node_identity_pkg::LINK_SPEED_CODE}; // RQ1 RQ3

    // Identifier is read-only to software; only reset and the EEPROM load write it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            node_id_upper_q <= node_identity_pkg::NODE_ID_RESET; // RQ5
            node_id_lower_q <= node_identity_pkg::NODE_ID_RESET; // RQ7
        end else if (clk_en && eeprom_load) begin
            node_id_upper_q <= eeprom_identifier[63:32]; // RQ4 RQ6
            node_id_lower_q <= eeprom_identifier[31:0]; // RQ7 RQ6
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rom_image_base_q <= node_identity_pkg::ROM_IMAGE_MAPPING_RESET[31:10];
        end else if (clk_en && wr_map) begin
            rom_image_base_q <= reg_wdata[31:node_identity_pkg::ROM_BASE_LSB]; // RQ8 RQ14
        end
    end

    // Counter advances once per bus reset if the ROM changed since the last one;
    // a software write takes priority over the automatic step
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            generation_q <= node_identity_pkg::GENERATION_RESET;
            rom_dirty_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_opts) begin
                generation_q <= reg_wdata[node_identity_pkg::GENERATION_MSB:node_identity_pkg::GENERATION_LSB]; // RQ2
            end else if (bus_reset && (rom_dirty_q || rom_changed)) begin
                generation_q <= generation_q + 2'h1; // RQ2
            end
            if (rom_changed) begin
                rom_dirty_q <= 1'b1; // Set wins over clear
            end else if (bus_reset) begin
                rom_dirty_q <= 1'b0;
            end
        end
    end

    // Capture registers have no defined reset value, so no reset term
    always_ff @(posedge clk_sys) begin
        if (clk_en && posted_write_fail) begin
            failed_write_offset_low_q <= failed_write_offset[31:0]; // RQ11 RQ12
            failed_write_offset_high_q <= {failed_requester_node, failed_write_offset[47:32]}; // RQ13
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rom_fetch_valid_q <= 1'b0;
            rom_fetch_addr_q <= 32'h0000_0000;
        end else if (clk_en) begin
            rom_fetch_valid_q <= rom_read_req && in_window;
            if (rom_read_req && in_window) begin
                rom_fetch_addr_q <= fetch_addr_d; // RQ9
            end
        end
    end

    always_comb begin
        unique case (reg_addr)
            node_identity_pkg::BUS_OPTION_FIELDS_OFS: rdata_d = opts_word;
            node_identity_pkg::NODE_ID_UPPER_OFS: rdata_d = node_id_upper_q;
            node_identity_pkg::NODE_ID_LOWER_OFS: rdata_d = node_id_lower_q;
            node_identity_pkg::ROM_IMAGE_MAPPING_OFS: rdata_d = map_word;
            node_identity_pkg::FAILED_WRITE_OFFSET_LOW_OFS: rdata_d = failed_write_offset_low_q;
            node_identity_pkg::FAILED_WRITE_OFFSET_HIGH_OFS: rdata_d = failed_write_offset_high_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (clk_en && reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign rom_fetch_valid = rom_fetch_valid_q;
    assign rom_fetch_addr = rom_fetch_addr_q;
endmodule

// [node_identity_checker.sv]
// Port assertions for the identity register bank.
// Assumes one clock; bench drops clk_en low once, and checks are disabled while it is low.
`timescale 1ns/1ns
module node_identity_checker(
    input wire logic clk_sys, rst_b, clk_en, reg_rd, rom_read_req, rom_fetch_valid, posted_write_fail,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] failed_requester_node,
    input wire logic [31:0] reg_rdata, rom_fetch_addr,
    input wire logic [47:0] rom_read_offset, failed_write_offset);
    logic [63:0] cap_q;
    logic seen_q;
    wire hit = rom_read_req && rom_read_offset >= 48'hffff_f000_0400 && rom_read_offset <= 48'hffff_f000_07ff;
    // Capture store is unknown until the first failure
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b) seen_q <= 1'b0;
        else seen_q <= seen_q | posted_write_fail;
    always_ff @(posedge clk_sys)
        if (posted_write_fail) cap_q <= {failed_requester_node, failed_write_offset};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b || !clk_en);
    sequence rd_at(a); reg_rd && reg_addr == a; endsequence
    chk_bus_opts: assert property (rd_at(8'h20) |=> reg_rdata[31:8] == 0 && reg_rdata[5:0] == 6'h02)
        else $error("bus options");
    chk_map_low: assert property (rd_at(8'h34) |=> reg_rdata[9:0] == 0) else $error("map low");
    chk_fetch_hit: assert property (hit |=> rom_fetch_valid && rom_fetch_addr[9:0] == $past(rom_read_offset[9:0]))
        else $error("fetch hit");
    chk_fetch_miss: assert property (!hit |=> !rom_fetch_valid) else $error("fetch miss");
    chk_fetch_hold: assert property (rom_read_req && !hit |=> $stable(rom_fetch_addr)) else $error("fetch hold");
    chk_fail_low: assert property (rd_at(8'h38) ##0 seen_q |=> reg_rdata == $past(cap_q[31:0])) else $error("low");
    chk_fail_high: assert property (rd_at(8'h3c) ##0 seen_q |=> reg_rdata == $past(cap_q[63:32])) else $error("hi");
    chk_reset_clear: assert property ($rose(rst_b) |-> reg_rdata == 0 && !rom_fetch_valid) else $error("reset");
endmodule
bind node_identity_rom_map_regs node_identity_checker node_identity_checker_inst(.*);

// [remote_node_model.sv]
// Remote node issuing quadlet reads.
// Assumes send pulses one clock per request.
`timescale 1ns/1ns
module remote_node_model(
    input wire logic clk_sys, send,
    input wire logic [47:0] ofs,
    output logic rom_read_req,
    output logic [47:0] rom_read_offset);
    // Offset is inverted each cycle between requests, so it returns to the last request value every second cycle
    always_ff @(posedge clk_sys) begin
        rom_read_req <= send;
        rom_read_offset <= send ? ofs : ~rom_read_offset;
    end
endmodule

// [testbench.sv]
// Bench for the identity register bank.
// Assumes package, checker and node model compiled first.
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, eeprom_load = 0, rom_changed = 0;
    logic bus_reset = 0, send = 0, posted_write_fail = 0, rom_fetch_valid, rom_read_req;
    logic [7:0] reg_addr = 8'h0;
    logic [15:0] failed_requester_node = 16'hbeef;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rom_fetch_addr;
    logic [47:0] ofs = 48'h0, rom_read_offset, failed_write_offset = 48'h1357_9bdf_2468;
    logic [63:0] eeprom_identifier = 64'h0123_4567_89ab_cdef;
    // Row: write flag, address, write data or expected read
    logic [40:0] rows[11] = '{{1'b0, 8'h20, 32'h2}, {1'b0, 8'h24, 32'h0}, {1'b0, 8'h28, 32'h0}, {1'b0, 8'h34, 32'h0},
        {1'b0, 8'h10, 32'h0}, {1'b1, 8'h34, 32'hffffffff}, {1'b0, 8'h34, 32'hfffffc00}, {1'b1, 8'h24, 32'hffffffff},
        {1'b0, 8'h24, 32'h0}, {1'b1, 8'h20, 32'hffffffff}, {1'b0, 8'h20, 32'hc2}};
    int failures = 0, checked = 0, cyc = 0;
    node_identity_rom_map_regs node_identity_rom_map_regs_inst(.*);
    remote_node_model remote_node_model_inst(.*);
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc == 3000) begin failures++; finish_test(); end
    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(logic [31:0] g, e);
        checked++;
        if (g !== e) begin failures++; $display("unexpected %0t got %h want %h", $time, g, e); end
    endtask
    task automatic acc(logic [40:0] r);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= r;
        reg_rd <= !r[40];
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        #1 if (!r[40]) cmp(reg_rdata, r[31:0]);
    endtask
    task automatic ev(logic [3:0] m);
        @(posedge clk_sys);
        {eeprom_load, rom_changed, bus_reset, posted_write_fail} <= m;
        @(posedge clk_sys);
        {eeprom_load, rom_changed, bus_reset, posted_write_fail} <= 4'h0;
    endtask
    task automatic fetch(logic [47:0] o, logic [31:0] e);
        @(posedge clk_sys);
        {send, ofs} <= {1'b1, o};
        @(posedge clk_sys);
        send <= 1'b0;
        @(posedge clk_sys);
        #1 cmp(rom_fetch_valid, |e);
        if (e != 0) cmp(rom_fetch_addr, e);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) acc(rows[i]);
        acc({1'b1, 8'h34, 32'h1234_5400});
        ev(4'h8);
        acc({1'b0, 8'h24, 32'h0123_4567});
        acc({1'b0, 8'h28, 32'h89ab_cdef});
        ev(4'h4);
        ev(4'h2);
        acc({1'b0, 8'h20, 32'h2});
        fetch(48'hffff_f000_07fc, 32'h1234_57fc);
        fetch(48'hffff_f000_0800, 32'h0);
        ev(4'h1);
        acc({1'b1, 8'h38, 32'h0});
        acc({1'b0, 8'h38, 32'h9bdf_2468});
        acc({1'b0, 8'h3c, 32'hbeef_1357});
        // Frozen clock enable must swallow a mapping write
        @(posedge clk_sys) clk_en <= 1'b0;
        acc({1'b1, 8'h34, 32'h0});
        @(posedge clk_sys) clk_en <= 1'b1;
        acc({1'b0, 8'h34, 32'h1234_5400});
        // Mid-run hardware reset drops the loaded identifier and the base
        @(posedge clk_sys) rst_b <= 1'b0;
        @(posedge clk_sys) rst_b <= 1'b1;
        acc({1'b0, 8'h24, 32'h0});
        acc({1'b0, 8'h28, 32'h0});
        acc({1'b0, 8'h34, 32'h0});
        finish_test();
    end
endmodule
